//--- tbtl_regs.svh
// Purpose: offsets, field positions, reset values and timing counts
// Assumes: hclk at 200 MHz, times in ns or us
// Notes: cycle counts follow from times and clock
`ifndef TBTL_REGS_SVH
`define TBTL_REGS_SVH

// register byte offsets
`define TBTL_CTRL_OFS 8'h00
`define TBTL_STAT_OFS 8'h04
// control fields
`define TBTL_CTRL_MAN_EN 0
`define TBTL_CTRL_MAN_100 1
`define TBTL_CTRL_MAN_FD 2
`define TBTL_CTRL_JAB_EN 3
`define TBTL_CTRL_RESTART 4
`define TBTL_CTRL_RST 4'h8

// clock and derived rates
`define TBTL_CLK_MHZ 200
`define TBTL_MII10_KHZ 2500
`define TBTL_MII100_KHZ 25000
`define TBTL_HB_MHZ 20
`define TBTL_NS2CYC(ns) ((((ns) * `TBTL_CLK_MHZ) + 999) / 1000)

// line timing
`define TBTL_MID_MIN_NS 75
`define TBTL_IDLE_NS 250
`define TBTL_SIL_NS 400
`define TBTL_LP_MAX_NS 200
`define TBTL_FLP_DATA_US 100
`define TBTL_BURST_GAP_US 200
`define TBTL_FLP_MIN_PULSES 17
`define TBTL_SPEED_SW_MAX_US 5000
`define TBTL_JAB_US 32000
`define TBTL_UNJAB_US 314000
`define TBTL_LINK_LOSS_US 100000

`endif

//--- tbtl_pkg.sv
// Purpose: types shared by the link and negotiation logic
// Assumes: nothing beyond SystemVerilog packages
// Notes: ability order follows the negotiation page bits 9..5
package tbtl_pkg;

  typedef enum logic [2:0] {MODE_NONE, MODE_10H, MODE_10F, MODE_TXH, MODE_TXF, MODE_T4} tbtl_mode_t;

  typedef enum logic [1:0] {RX_IDLE, RX_HUNT, RX_DATA} tbtl_rx_t;

  typedef struct packed {
    logic jabber_en;
    logic manual_fd;
    logic manual_100;
    logic manual_en;
  } tbtl_ctrl_t;

  typedef struct packed {
    logic t4;
    logic txf;
    logic txh;
    logic tf;
    logic th;
  } tbtl_abil_t;

endpackage : tbtl_pkg

//--- tbtl_link.sv
// Purpose: 10BASE-T line coding, link classing and mode selection
// Assumes: receive pair digitised to sign and energy flags
// Notes: 100BASE-TX data path lives elsewhere and follows speed_100
`timescale 1ns/1ps
`include "tbtl_regs.svh"

// Operation
// R1 - negotiate 10H, 10F, TXH and TXF
// R2 - adapter speed follows negotiation result
// R3 - negotiation disable pin only in repeater
// R4 - four-pair advertise adds T4 ability
// R5 - manual speed and duplex from registers
// R6 - companion used only in adapter mode
// R7 - companion disabled until T4 resolved
// R8 - companion reports link while enabled
// R9 - link pulses without bursts give 10M
// R10 - MII clocks follow speed within 5ms
// R11 - address 0 to 3 from pins
// R12 - derive 20M, 10M, 2.5M from clock
// R13 - Manchester encode, mid-bit transition per bit
// R14 - line starts within three bit times
// R15 - decode Manchester into 2.5M nibbles
// R16 - single cycle noise rejected after silence
// R17 - qualified activity asserts carrier sense
// R18 - early idle in frame flags error
// R19 - collision when sending while receiving
// R20 - classify pulses, bursts and fast idles
// R21 - invert receive data on reversed pulses
// R22 - jabber blocks line until long quiet
// R23 - full duplex drops collision and loopback
module tbtl_link
  import tbtl_pkg::*;
#(
  parameter int JAB_US = `TBTL_JAB_US,
  parameter int UNJAB_US = `TBTL_UNJAB_US,
  parameter int LINK_US = `TBTL_LINK_LOSS_US
) (
  // clock and reset
  input wire logic hclk,
  input wire logic hresetn,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // mii toward the mac
  output logic mii_tx_clk,
  input wire logic [3:0] mii_txd,
  input wire logic mii_tx_en,
  output logic mii_rx_clk,
  output logic [3:0] mii_rxd,
  output logic mii_rx_dv,
  output logic mii_rx_er,
  output logic mii_crs,
  output logic mii_col,
  // line side
  input wire logic line_rx_level,
  input wire logic line_rx_energy,
  input wire logic tx_signal_detect,
  output logic line_tx_level,
  output logic line_tx_active,
  // configuration and companion pins
  input wire logic four_pair_advertise,
  input wire logic companion_link_good,
  input wire logic addr_select_hi,
  input wire logic addr_select_lo,
  input wire logic repeater_mode,
  input wire logic an_disable,
  output logic companion_phy_disable,
  output logic [4:0] mgmt_addr,
  output logic speed_100,
  output logic full_duplex
);

  localparam logic [5:0] H10 = 6'(`TBTL_CLK_MHZ * 1000 / (2 * `TBTL_MII10_KHZ));
  localparam logic [5:0] H100 = 6'(`TBTL_CLK_MHZ * 1000 / (2 * `TBTL_MII100_KHZ));
  localparam logic [3:0] HB_CYC = 4'(`TBTL_CLK_MHZ / `TBTL_HB_MHZ);
  localparam logic [5:0] MID_CYC = 6'(`TBTL_NS2CYC(`TBTL_MID_MIN_NS));
  localparam logic [5:0] IDLE_CYC = 6'(`TBTL_NS2CYC(`TBTL_IDLE_NS));
  localparam logic [6:0] SIL_CYC = 7'(`TBTL_NS2CYC(`TBTL_SIL_NS));
  localparam logic [5:0] LP_CYC = 6'(`TBTL_NS2CYC(`TBTL_LP_MAX_NS));
  localparam logic [7:0] US_CYC = 8'(`TBTL_CLK_MHZ);

  // pin synchroniser, two stages
  logic [13:0] pin_raw;
  logic [13:0] pin_s1;
  logic [13:0] pin_s2;
  assign pin_raw = {mii_txd, mii_tx_en, line_rx_level, line_rx_energy, tx_signal_detect,
                    four_pair_advertise, companion_link_good, addr_select_hi, addr_select_lo,
                    repeater_mode, an_disable};
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1 <= 14'h0000;
      pin_s2 <= 14'h0000;
    end else begin
      pin_s1 <= pin_raw;
      pin_s2 <= pin_s1;
    end
  end
  wire [3:0] s_txd = pin_s2[13:10];
  wire s_txen = pin_s2[9];
  wire s_rxl = pin_s2[8];
  wire s_rxe = pin_s2[7];
  wire s_sd = pin_s2[6];
  wire s_four_pair_advertise = pin_s2[5];
  wire s_clink = pin_s2[4];
  wire s_rpt = pin_s2[1];
  wire s_andis = pin_s2[0];

  // microsecond tick for the long timers
  logic [7:0] us_cnt;
  wire us_tick = (us_cnt == US_CYC - 8'h01);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) us_cnt <= 8'h00;
    else us_cnt <= us_tick ? 8'h00 : us_cnt + 8'h01;
  end

  // bus decode; zero wait states, every response okay
  tbtl_ctrl_t ctrl_reg;
  logic an_restart;
  logic wr_pend;
  logic [7:0] wr_addr;
  logic [31:0] status_word;
  wire ap = hsel & htrans[1] & hready;
  wire ap_wr = ap & hwrite & (hsize == 3'h2);
  wire sel_ctrl = (haddr[7:0] == `TBTL_CTRL_OFS);
  wire sel_stat = (haddr[7:0] == `TBTL_STAT_OFS);
  wire [31:0] rd_val = sel_ctrl ? {28'h0000000, ctrl_reg} : sel_stat ? status_word : 32'h00000000;
  wire wr_ctrl = wr_pend & (wr_addr == `TBTL_CTRL_OFS);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend <= 1'b0;
      wr_addr <= 8'h00;
      hrdata <= 32'h00000000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend <= ap_wr;
      wr_addr <= haddr[7:0];
      hrdata <= (ap & !hwrite) ? rd_val : 32'h00000000;
    end
  end

  // control register; restart self-clears
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_reg <= `TBTL_CTRL_RST;
      an_restart <= 1'b0;
    end else begin
      an_restart <= wr_ctrl & hwdata[`TBTL_CTRL_RESTART];
      if (wr_ctrl) ctrl_reg <= hwdata[3:0]; // R5
    end
  end

  // mii clock divider; a new speed applies to the half period in progress
  tbtl_mode_t mode_reg;
  logic [5:0] clk_cnt;
  wire [5:0] half_lim = speed_100 ? H100 : H10; // R10 R12
  wire clk_tog = (clk_cnt >= half_lim - 6'h01);
  wire mii_fall = clk_tog & mii_tx_clk;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_cnt <= 6'h00;
      mii_tx_clk <= 1'b0;
      mii_rx_clk <= 1'b0;
    end else begin
      clk_cnt <= clk_tog ? 6'h00 : clk_cnt + 6'h01;
      if (clk_tog) begin
        mii_tx_clk <= ~mii_tx_clk; // R10
        mii_rx_clk <= ~mii_tx_clk;
      end
    end
  end

  // manchester encoder; nibble taken at mid tx clock, well inside three bit times
  wire is10 = (mode_reg == MODE_10H) | (mode_reg == MODE_10F);
  logic tx_on;
  logic jab_reg;
  logic [3:0] tx_sh;
  logic [3:0] hb_cnt;
  logic half_ph;
  logic [1:0] bidx;
  wire cur_bit = tx_sh[bidx];
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_on <= 1'b0;
      tx_sh <= 4'h0;
      hb_cnt <= 4'h0;
      half_ph <= 1'b0;
      bidx <= 2'h0;
    end else if (mii_fall) begin
      tx_on <= is10 & s_txen & !jab_reg; // R14
      tx_sh <= s_txd;
      hb_cnt <= 4'h0;
      half_ph <= 1'b0;
      bidx <= 2'h0;
    end else if (tx_on) begin
      hb_cnt <= (hb_cnt == HB_CYC - 4'h1) ? 4'h0 : hb_cnt + 4'h1; // R12
      if (hb_cnt == HB_CYC - 4'h1) begin
        half_ph <= ~half_ph;
        if (half_ph) bidx <= bidx + 2'h1; // R13
      end
    end
  end

  // first half inverted, second half true: rising mid-bit for a one
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      line_tx_level <= 1'b0;
      line_tx_active <= 1'b0;
    end else begin
      line_tx_level <= tx_on & !jab_reg & (half_ph ? cur_bit : ~cur_bit); // R13
      line_tx_active <= tx_on & !jab_reg; // R22
    end
  end

  // jabber: one counter serves the run and quiet windows
  logic [19:0] jab_cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      jab_reg <= 1'b0;
      jab_cnt <= 20'h00000;
    end else if (!ctrl_reg.jabber_en) begin
      jab_reg <= 1'b0;
      jab_cnt <= 20'h00000;
    end else if (!jab_reg) begin
      if (!(s_txen & is10)) jab_cnt <= 20'h00000;
      else if (us_tick) begin
        jab_reg <= (jab_cnt >= 20'(JAB_US - 1)); // R22
        jab_cnt <= (jab_cnt >= 20'(JAB_US - 1)) ? 20'h00000 : jab_cnt + 20'h00001;
      end
    end else begin
      if (s_txen) jab_cnt <= 20'h00000;
      else if (us_tick) begin
        jab_reg <= !(jab_cnt >= 20'(UNJAB_US - 1)); // R22
        jab_cnt <= jab_cnt + 20'h00001;
      end
    end
  end

  // squelch qualifier; a lone cycle after silence never reaches three edges
  logic pol_inv;
  logic rl_d;
  logic rxe_d;
  logic quiet_pre;
  logic [6:0] sil_cnt;
  logic [1:0] e_cnt;
  wire rl = s_rxl ^ pol_inv; // R21
  wire rx_edge = rl ^ rl_d;
  wire quiet_now = rxe_d ? quiet_pre : (sil_cnt >= SIL_CYC);
  wire qual = s_rxe & (!quiet_now | (e_cnt == 2'h3)); // R16
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rl_d <= 1'b0;
      rxe_d <= 1'b0;
      quiet_pre <= 1'b1;
      sil_cnt <= 7'h00;
      e_cnt <= 2'h0;
    end else begin
      rl_d <= rl;
      rxe_d <= s_rxe;
      quiet_pre <= quiet_now;
      if (!s_rxe) begin
        if (sil_cnt != 7'h7F) sil_cnt <= sil_cnt + 7'h01;
        e_cnt <= 2'h0;
      end else begin
        sil_cnt <= 7'h00;
        if (rx_edge & (e_cnt != 2'h3)) e_cnt <= e_cnt + 2'h1; // R16
      end
    end
  end

  // manchester decoder; edges too soon after a mid-bit are bit boundaries
  tbtl_rx_t rx_state;
  logic [5:0] sb_cnt;
  logic prev_bit;
  logic [3:0] nib;
  logic [1:0] bcnt;
  logic [3:0] hold;
  logic hold_v;
  logic err_pend;
  wire mid = qual & rx_edge & (sb_cnt >= MID_CYC); // R15
  wire rx_idle = (sb_cnt == IDLE_CYC) & !mid;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_state <= RX_IDLE;
      sb_cnt <= 6'h3F;
      prev_bit <= 1'b0;
      nib <= 4'h0;
      bcnt <= 2'h0;
      hold <= 4'h0;
      hold_v <= 1'b0;
      err_pend <= 1'b0;
      mii_rxd <= 4'h0;
      mii_rx_dv <= 1'b0;
      mii_rx_er <= 1'b0;
    end else begin
      if (mid) sb_cnt <= 6'h00;
      else if (sb_cnt != 6'h3F) sb_cnt <= sb_cnt + 6'h01;
      // nibble out at falling rx clock
      if (mii_fall) begin
        mii_rx_er <= err_pend; // R18
        err_pend <= 1'b0;
        if (hold_v) begin
          mii_rxd <= hold; // R15
          mii_rx_dv <= 1'b1;
          hold_v <= 1'b0;
        end else if (rx_state == RX_IDLE) mii_rx_dv <= 1'b0;
      end
      case (rx_state)
        RX_IDLE: begin
          if (mid) rx_state <= RX_HUNT;
          prev_bit <= rl;
        end
        RX_HUNT: begin
          if (rx_idle) rx_state <= RX_IDLE;
          else if (mid) begin
            prev_bit <= rl;
            if (prev_bit & rl) begin
              rx_state <= RX_DATA;
              hold <= 4'hD;
              hold_v <= 1'b1;
              bcnt <= 2'h0;
            end
          end
        end
        RX_DATA: begin
          if (rx_idle) begin
            rx_state <= RX_IDLE;
            if (bcnt != 2'h0) err_pend <= 1'b1; // R18
          end else if (mid) begin
            nib <= {rl, nib[3:1]};
            bcnt <= bcnt + 2'h1;
            if (bcnt == 2'h3) begin
              hold <= {rl, nib[3:1]}; // R15
              hold_v <= 1'b1;
            end
          end
        end
        default: rx_state <= RX_IDLE;
      endcase
    end
  end

  // short energy runs are link pulses; their sign shows pair polarity
  logic [5:0] en_run;
  logic lvl_seen;
  wire lp_hit = rxe_d & !s_rxe & (en_run < LP_CYC); // R20
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_run <= 6'h00;
      lvl_seen <= 1'b0;
    end else if (s_rxe & !rxe_d) begin
      en_run <= 6'h01;
      lvl_seen <= s_rxl;
    end else if (s_rxe) begin
      if (en_run != 6'h3F) en_run <= en_run + 6'h01;
      lvl_seen <= lvl_seen | s_rxl;
    end
  end

  // two reversed pulses flip the receive sense
  logic [1:0] neg_cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      neg_cnt <= 2'h0;
      pol_inv <= 1'b0;
    end else if (lp_hit) begin
      if (lvl_seen) begin
        neg_cnt <= 2'h0;
        pol_inv <= 1'b0; // R21
      end else begin
        if (neg_cnt != 2'h3) neg_cnt <= neg_cnt + 2'h1;
        if (neg_cnt != 2'h0) pol_inv <= 1'b1; // R21
      end
    end
  end

  // burst decoder: a pulse soon after a clock pulse is a one
  logic [7:0] gap_us;
  logic [4:0] burst_cnt;
  logic in_burst;
  logic last_clk;
  logic [15:0] page;
  logic flp_seen;
  logic nlp_seen;
  logic link_alive;
  tbtl_abil_t partner;
  wire burst_end = in_burst & !lp_hit & (gap_us == 8'(`TBTL_BURST_GAP_US));
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      gap_us <= 8'hFF;
      burst_cnt <= 5'h00;
      in_burst <= 1'b0;
      last_clk <= 1'b0;
      page <= 16'h0000;
      partner <= 5'h00;
    end else if (lp_hit) begin
      gap_us <= 8'h00;
      in_burst <= 1'b1;
      last_clk <= !(in_burst & last_clk & (gap_us < 8'(`TBTL_FLP_DATA_US)));
      burst_cnt <= !in_burst ? 5'h01 : (burst_cnt == 5'h1F) ? burst_cnt : burst_cnt + 5'h01;
      if (in_burst & last_clk) page <= {gap_us < 8'(`TBTL_FLP_DATA_US), page[15:1]};
    end else begin
      if (us_tick & (gap_us != 8'hFF)) gap_us <= gap_us + 8'h01;
      if (burst_end) begin
        in_burst <= 1'b0;
        if (burst_cnt >= 5'(`TBTL_FLP_MIN_PULSES)) partner <= page[9:5]; // R20
      end
    end
  end

  // sticky classes, cleared on restart or link loss; a new class wins
  wire flp_done = burst_end & (burst_cnt >= 5'(`TBTL_FLP_MIN_PULSES));
  wire nlp_done = burst_end & (burst_cnt == 5'h01);
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      flp_seen <= 1'b0;
      nlp_seen <= 1'b0;
    end else begin
      if (an_restart | !link_alive) begin
        flp_seen <= 1'b0;
        nlp_seen <= 1'b0;
      end
      if (flp_done) flp_seen <= 1'b1; // R20
      if (nlp_done) nlp_seen <= 1'b1; // R20
    end
  end

  // link loss timer, kept alive by pulses or fast idles
  logic [19:0] link_cnt;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      link_cnt <= 20'(LINK_US);
      link_alive <= 1'b0;
    end else begin
      link_alive <= (link_cnt < 20'(LINK_US));
      if (lp_hit | s_sd) link_cnt <= 20'h00000;
      else if (us_tick & (link_cnt < 20'(LINK_US))) link_cnt <= link_cnt + 20'h00001;
    end
  end

  // mode resolution: manual, negotiated, then parallel detect
  wire adapter = !s_rpt;
  wire an_en = adapter | !s_andis; // R3
  tbtl_abil_t loc;
  tbtl_abil_t common;
  assign loc = {s_four_pair_advertise & adapter, 4'hF}; // R1 R4
  assign common = loc & partner;
  wire tbtl_mode_t an_mode = common.txf ? MODE_TXF : common.t4 ? MODE_T4 :
                             common.txh ? MODE_TXH : common.tf ? MODE_10F :
                             common.th ? MODE_10H : MODE_NONE; // R1 R4
  wire tbtl_mode_t man_mode = ctrl_reg.manual_100 ? (ctrl_reg.manual_fd ? MODE_TXF : MODE_TXH) :
                              (ctrl_reg.manual_fd ? MODE_10F : MODE_10H); // R5
  wire tbtl_mode_t mode_next = (ctrl_reg.manual_en | !an_en) ? man_mode : // R5 R3
                               flp_seen ? an_mode : // R2
                               s_sd ? MODE_TXH : // R20
                               (loc.t4 & s_clink) ? MODE_T4 : // R8
                               nlp_seen ? MODE_10H : MODE_NONE; // R9
  wire fd_now = (mode_reg == MODE_10F) | (mode_reg == MODE_TXF);
  wire link_ok = (mode_reg == MODE_T4) ? s_clink : (mode_reg != MODE_NONE) & link_alive;
  assign status_word = {19'h00000, partner, 1'b0, s_clink, jab_reg, pol_inv,
                        mode_reg == MODE_T4, full_duplex, speed_100, link_ok};

  // mode and pin-facing outputs
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mode_reg <= MODE_NONE;
      speed_100 <= 1'b0;
      full_duplex <= 1'b0;
      companion_phy_disable <= 1'b1;
      mgmt_addr <= 5'h00;
    end else begin
      mode_reg <= mode_next; // R2
      speed_100 <= (mode_next == MODE_TXH) | (mode_next == MODE_TXF) | (mode_next == MODE_T4);
      full_duplex <= (mode_next == MODE_10F) | (mode_next == MODE_TXF);
      companion_phy_disable <= !(adapter & (mode_next == MODE_T4)); // R6 R7
      mgmt_addr <= {3'h0, pin_s2[3], pin_s2[2]}; // R11
    end
  end

  // carrier and collision; full duplex drops loopback
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      mii_crs <= 1'b0;
      mii_col <= 1'b0;
    end else begin
      mii_crs <= qual | lp_hit | (tx_on & is10 & !fd_now); // R17 R23
      mii_col <= tx_on & qual & is10 & !fd_now; // R19 R23
    end
  end

endmodule : tbtl_link

//--- tbtl_link_props.sv
// Purpose: port-level checks for tbtl_link
// Assumes: one hclk domain, asynchronous active-low reset
// Notes: half periods checked once speed settles
`timescale 1ns/1ps
module tbtl_link_props (
  // clock and reset
  input logic hclk,
  input logic hresetn,
  // register bus
  input logic hsel,
  input logic [1:0] htrans,
  input logic hwrite,
  input logic hready,
  input logic [31:0] hrdata,
  input logic hreadyout,
  input logic hresp,
  // mii
  input logic mii_tx_clk,
  input logic mii_rx_clk,
  input logic [3:0] mii_rxd,
  input logic mii_rx_dv,
  input logic mii_rx_er,
  input logic mii_col,
  // line and pins
  input logic line_tx_level,
  input logic line_tx_active,
  input logic addr_select_hi,
  input logic addr_select_lo,
  input logic companion_phy_disable,
  input logic [4:0] mgmt_addr,
  input logic speed_100,
  input logic full_duplex
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  logic clk_q, lvl_q, spd_q, seen_reg;
  logic [7:0] half_cnt, spd_cnt, run_cnt;
  wire tog = mii_tx_clk != clk_q;
  wire rd_take = hsel && htrans[1] && !hwrite && hready;
  // half and speed counters saturate and never wrap into a false match
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      clk_q <= 1'b0; lvl_q <= 1'b0; spd_q <= 1'b0; seen_reg <= 1'b0;
      half_cnt <= 8'h00; spd_cnt <= 8'h00; run_cnt <= 8'hFF;
    end else begin
      clk_q <= mii_tx_clk; lvl_q <= line_tx_level; spd_q <= speed_100; seen_reg <= seen_reg | tog;
      half_cnt <= tog ? 8'h00 : half_cnt + {7'h00, half_cnt != 8'hFF};
      spd_cnt <= (speed_100 != spd_q) ? 8'h00 : spd_cnt + {7'h00, spd_cnt != 8'hFF};
      run_cnt <= !line_tx_active ? 8'hFF : ((line_tx_level != lvl_q) ? 8'h00 : run_cnt + 8'h01);
    end
  end
  bus_okay_a: assert property (hreadyout && !hresp)
    else $error("bus not okay");
  rdata_idle_a: assert property (!$past(rd_take) |-> hrdata == 32'h0)
    else $error("stray read data");
  addr_pins_a: assert property (($stable(addr_select_hi) && $stable(addr_select_lo))[*6]
    |-> mgmt_addr == {3'h0, addr_select_hi, addr_select_lo}) else $error("address off pins");
  companion_hold_a: assert property ($fell(companion_phy_disable) |-> ##[0:2] (speed_100 && !full_duplex))
    else $error("companion freed early");
  clk_match_a: assert property (mii_rx_clk == mii_tx_clk)
    else $error("rx and tx clocks differ");
  half_period_a: assert property (tog && seen_reg && spd_cnt > 8'd200
    |-> half_cnt == (speed_100 ? 8'd3 : 8'd39)) else $error("bad half period");
  mid_bit_a: assert property (line_tx_active && $past(line_tx_active) && line_tx_level != lvl_q
    |-> run_cnt == 8'd9 || run_cnt == 8'd19) else $error("bad line run");
  tx_refused_a: assert property (line_tx_active |-> !speed_100)
    else $error("line driven at 100M");
  col_half_a: assert property (mii_col |-> !full_duplex && !speed_100)
    else $error("collision not in 10H");
  rxd_change_a: assert property ($changed(mii_rxd) |-> !mii_rx_clk)
    else $error("rxd moved, clock high");
  rx_err_len_a: assert property ($rose(mii_rx_er) |-> mii_rx_er[*8])
    else $error("rx error too short");
  cover property ($rose(mii_rx_dv));
  cover property ($rose(mii_col));
  cover property ($fell(companion_phy_disable));
  cover property ($rose(mii_rx_er));
endmodule : tbtl_link_props

bind tbtl_link tbtl_link_props u_props (.*);

//--- tbtl_mac_model.sv
// Purpose: MAC transmit side of the MII
// Assumes: nibbles change just after the rising tx clock
// Notes: sends 5 then A; data toggles so stale nibbles show
`timescale 1ns/1ps
module tbtl_mac_model (
  // clock and reset
  input logic hclk,
  input logic hresetn,
  // bench control
  input logic send,
  // mii transmit
  input logic mii_tx_clk,
  output logic mii_tx_en,
  output logic [3:0] mii_txd
);
  logic txc_q;
  wire txc_rise = mii_tx_clk && !txc_q;
  // moves only on a rising tx clock
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      txc_q <= 1'b0; mii_tx_en <= 1'b0; mii_txd <= 4'h5;
    end else begin
      txc_q <= mii_tx_clk;
      if (txc_rise) begin
        mii_tx_en <= send;
        mii_txd <= (send && !mii_tx_en) ? 4'h5 : ~mii_txd;
      end
    end
  end
endmodule : tbtl_mac_model

//--- testbench.sv
// Purpose: directed tests of tbtl_link through bus, mii and line pins
// Assumes: 200 MHz hclk, shortened jabber and link timers
// Notes: receive line as sign plus energy, 20 cycles per bit
`timescale 1ns/1ps
`include "tbtl_regs.svh"
module testbench;
  logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, send = 1'b0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd, hrdata;
  logic rx_lvl = 1'b0, rx_nrg = 1'b0, sig_det = 1'b0, four_adv = 1'b0, comp_good = 1'b0, a_hi = 1'b1, a_lo = 1'b0;
  logic rxc_q = 1'b0, er_seen = 1'b0, col_seen = 1'b0;
  logic hreadyout, hresp, mii_tx_clk, mii_rx_clk, mii_rx_dv, mii_rx_er, mii_crs, mii_col, mii_tx_en;
  logic line_tx_level, line_tx_active, companion_phy_disable, speed_100, full_duplex;
  logic [3:0] mii_rxd, mii_txd;
  logic [4:0] mgmt_addr;
  logic [3:0] nq[$];
  int bad_count = 0, comparisons = 0;
  always #2.5 hclk = ~hclk;
  tbtl_link #(.JAB_US(20), .UNJAB_US(30), .LINK_US(2000)) dut (.hclk, .hresetn, .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .mii_tx_clk, .mii_txd,
    .mii_tx_en, .mii_rx_clk, .mii_rxd, .mii_rx_dv, .mii_rx_er, .mii_crs, .mii_col, .line_rx_level(rx_lvl),
    .line_rx_energy(rx_nrg), .tx_signal_detect(sig_det), .line_tx_level, .line_tx_active,
    .four_pair_advertise(four_adv), .companion_link_good(comp_good), .addr_select_hi(a_hi),
    .addr_select_lo(a_lo), .repeater_mode(1'b0), .an_disable(1'b0), .companion_phy_disable, .mgmt_addr,
    .speed_100, .full_duplex);
  tbtl_mac_model mac (.hclk, .hresetn, .send, .mii_tx_clk, .mii_tx_en, .mii_txd);
  // nibbles at falling rx clock, sticky error and collision
  always @(posedge hclk) begin
    rxc_q <= mii_rx_clk;
    if (rxc_q && !mii_rx_clk && mii_rx_dv && (nq.size() == 0 || mii_rxd !== nq[$])) nq.push_back(mii_rxd);
    if (mii_rx_er) er_seen = 1'b1;
    if (mii_col) col_seen = 1'b1;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk
  // single word transfer, waits on hready
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rdat);
    hsel <= 1'b1; htrans <= 2'h2; haddr <= {24'h0, a}; hwrite <= wr; hsize <= 3'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rdat = hrdata;
  endtask : bus
  // manchester frame on the receive pair, lsb first
  task automatic frame(input logic [31:0] bits, input int n);
    rx_nrg <= 1'b1;
    for (int i = 0; i < n; i++) begin
      rx_lvl <= ~bits[i];
      repeat (10) @(posedge hclk);
      rx_lvl <= bits[i];
      repeat (10) @(posedge hclk);
      if (i == 12) chk(mii_crs, 1'b1, "carrier");
    end
    rx_nrg <= 1'b0;
    rx_lvl <= 1'b0;
    repeat (200) @(posedge hclk);
  endtask : frame
  // start latency and first two nibbles on the line
  task automatic tx_check;
    int t = 0;
    logic [7:0] pat = 8'hA5;
    send <= 1'b1;
    while (mii_tx_en !== 1'b1 && t < 200) begin @(posedge hclk); t++; end
    t = 0;
    while (line_tx_active !== 1'b1 && t < 100) begin @(posedge hclk); t++; end
    chk(t < 60, 1'b1, "line start delay");
    for (int i = 0; i < 8; i++) begin
      repeat (i == 0 ? 15 : 20) @(posedge hclk);
      chk(line_tx_level, pat[i], "line bit");
    end
  endtask : tx_check
  task automatic complete_run;
    if (bad_count == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : complete_run
  // hang guard, about one and a half times the expected run
  initial begin
    #400000;
    bad_count++;
    complete_run();
  end
  // main sequence
  initial begin
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    repeat (4) @(posedge hclk);
    chk(mgmt_addr, 5'h02, "address");
    chk(companion_phy_disable, 1'b1, "companion held off");
    bus(1'b0, `TBTL_CTRL_OFS, 32'h0, rd); chk(rd, 32'h8, "control reset");
    bus(1'b0, 8'h10, 32'h0, rd); chk(rd, 32'h0, "unmapped read");
    rx_lvl <= 1'b1; rx_nrg <= 1'b1;
    repeat (20) @(posedge hclk);
    rx_lvl <= 1'b0; rx_nrg <= 1'b0;
    a_hi <= 1'b0; a_lo <= 1'b1;
    repeat (41000) @(posedge hclk);
    chk(mgmt_addr, 5'h01, "address moved");
    bus(1'b0, `TBTL_STAT_OFS, 32'h0, rd); chk(rd & 32'h7, 32'h1, "link pulse gives 10M");
    four_adv <= 1'b1; comp_good <= 1'b1;
    repeat (10) @(posedge hclk);
    chk({companion_phy_disable, speed_100}, 2'b01, "four-pair mode");
    bus(1'b0, `TBTL_STAT_OFS, 32'h0, rd); chk(rd & 32'h48, 32'h48, "four-pair status");
    comp_good <= 1'b0;
    repeat (10) @(posedge hclk);
    chk({companion_phy_disable, speed_100}, 2'b10, "companion off again");
    sig_det <= 1'b1;
    repeat (10) @(posedge hclk);
    chk({speed_100, full_duplex}, 2'b10, "parallel detect 100");
    bus(1'b1, `TBTL_CTRL_OFS, 32'h7, rd); repeat (3) @(posedge hclk);
    chk({speed_100, full_duplex}, 2'b11, "manual 100 full");
    bus(1'b0, `TBTL_STAT_OFS, 32'h0, rd); chk(rd & 32'h6, 32'h6, "manual status");
    bus(1'b1, `TBTL_CTRL_OFS, 32'h1, rd); repeat (200) @(posedge hclk);
    chk({speed_100, full_duplex}, 2'b00, "manual 10 half");
    er_seen = 1'b0; col_seen = 1'b0;
    fork
      tx_check();
      frame(32'h00A5D555, 24);
    join
    send <= 1'b0;
    chk(nq[0], 4'hD, "first nibble");
    chk(nq[1], 4'h5, "second nibble");
    chk(nq[2], 4'hA, "third nibble");
    chk({col_seen, er_seen}, 2'b10, "half duplex collision");
    bus(1'b1, `TBTL_CTRL_OFS, 32'h5, rd); repeat (200) @(posedge hclk);
    er_seen = 1'b0; col_seen = 1'b0;
    send <= 1'b1;
    frame(32'h0001D555, 18);
    send <= 1'b0;
    chk({col_seen, er_seen}, 2'b01, "full duplex cut frame");
    bus(1'b1, `TBTL_CTRL_OFS, 32'h9, rd); send <= 1'b1;
    repeat (4300) @(posedge hclk);
    bus(1'b0, `TBTL_STAT_OFS, 32'h0, rd); chk(rd & 32'h20, 32'h20, "jabber set");
    chk(line_tx_active, 1'b0, "line blocked");
    send <= 1'b0;
    repeat (6400) @(posedge hclk);
    bus(1'b0, `TBTL_STAT_OFS, 32'h0, rd); chk(rd & 32'h20, 32'h0, "jabber cleared");
    complete_run();
  end
endmodule : testbench
